// ---- design/servo_option_ctrl.sv ----
// Feedback source, indicator mode and stop control for the servo drive.
`timescale 1ns/100ps
`include "servo_option_map.svh"
module servo_option_ctrl
  import servo_option_pkg::*;
#(
  parameter bit LARGE_UNIT = 1'b0,
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
  parameter int FLASH_CYCLES = `FLASH_CYCLES,
  parameter int SWITCH_WIDTH = 20
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [15:0] option_switch_word,
  input wire logic [15:0] feedback_switch_word,
  input wire logic [15:0] stop_switch_word,
  input wire logic stopWordWrite,
  input wire logic [2:0] decimal_shift_setting,
  input wire logic ext_phase_a_pos,
  input wire logic ext_phase_a_neg,
  input wire logic ext_phase_b_pos,
  input wire logic ext_phase_b_neg,
  input wire logic ext_phase_c_pos,
  input wire logic ext_phase_c_neg,
  input wire logic encoderStep,
  input wire logic encoderDir,
  input wire logic encoderIndex,
  input wire logic line_feedback_select_b,
  input wire logic positioningDone,
  input wire logic servoOnIn,
  input wire logic serial_servo_off_cmd,
  input wire logic powerLoss,
  input wire logic motorStopped,
  input wire logic serialRxActive,
  input wire logic serialTxData,
  input wire logic indicatorTxData,
  input wire logic [SWITCH_WIDTH-1:0] switchPosition,
  input wire logic [SWITCH_WIDTH-1:0] switchFeedSpeed,
  output logic feedbackStep,
  output logic feedbackDir,
  output logic feedbackIndex,
  output logic lineFeedbackActive,
  output logic indicatorMode,
  output logic txOut,
  output logic [7:0] decimalPointSel,
  output logic [SWITCH_WIDTH+23:0] scaledPosition,
  output logic [SWITCH_WIDTH+23:0] scaledFeedSpeed,
  output logic servoOff,
  output logic dynamic_brake,
  output logic motorPowerOn,
  output logic brake_interlock_out,
  output logic holdBit
);
  servo_option_if selIf();
  logic [2:0] aSync1_q, aSync2_q;
  logic [1:0] phaseAB_q;
  logic lineStep_d, lineDir_d;
  logic lineEnable;
  logic posDone_q;
  logic indicatorLatched_q;
  logic rxSeen_q;
  logic flash_q;
  logic [31:0] flashCount_q;
  logic holdBit_q;
  stop_state_t stop_q;
  logic servoOffReq;
  logic coastSel;

  // Ten raised to a shift of zero to seven.
  function automatic logic [23:0] pow10(input logic [2:0] s);
    logic [23:0] r;
    r = 24'h1;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(s)) begin
        r = 24'(r * 24'ha);
      end
    end
    return r;
  endfunction

  assign selIf.selectRaw = line_feedback_select_b;
  contact_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) uDebounce (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .sel(selIf.filt)
  );

  // Pin inputs of the generator pass two flip-flops; only the positive
  // leg of each pair is decoded, the negative legs belong to the receiver.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      aSync1_q <= 3'h0;
      aSync2_q <= 3'h0;
    end else begin
      aSync1_q <= {ext_phase_c_pos, ext_phase_b_pos, ext_phase_a_pos};
      aSync2_q <= aSync1_q;
    end
  end

  // Quadrature decode: every A or B edge is one command unit.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phaseAB_q <= 2'h0;
    end else begin
      phaseAB_q <= aSync2_q[1:0];
    end
  end

  // Exactly one step per line pulse edge; no gear scaling here.
  always_comb begin
    lineStep_d = (aSync2_q[1:0] != phaseAB_q);
    lineDir_d = aSync2_q[0] ^ phaseAB_q[1];
  end

  // Positioning completion is a same-clock level and is tracked directly.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      posDone_q <= 1'b0;
    end else begin
      posDone_q <= positioningDone;
    end
  end

  // Source choice: enable bit, then contact, then post-positioning override.
  always_comb begin
    lineEnable = option_switch_word[`EXT_GEN_ENABLE_BIT]
      & selIf.selectOn
      & (feedback_switch_word[`POST_POS_FEEDBACK_BIT] | ~posDone_q);
  end

  // Feedback outputs are registered so the selected source never glitches.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      feedbackStep <= 1'b0;
      feedbackDir <= 1'b0;
      feedbackIndex <= 1'b0;
      lineFeedbackActive <= 1'b0;
    end else begin
      lineFeedbackActive <= lineEnable;
      if (lineEnable) begin
        feedbackStep <= lineStep_d;
        feedbackDir <= lineDir_d;
        // Phase C is only needed for index homing; an open input reads low.
        feedbackIndex <= aSync2_q[2];
      end else begin
        feedbackStep <= encoderStep;
        feedbackDir <= encoderDir;
        feedbackIndex <= encoderIndex;
      end
    end
  end

  // Enable follows the option bit every cycle until the first receive in indicator mode.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      indicatorLatched_q <= 1'b0;
      rxSeen_q <= 1'b0;
    end else if (!rxSeen_q) begin
      indicatorLatched_q <= option_switch_word[`INDICATOR_ENABLE_BIT];
      if (serialRxActive && indicatorLatched_q) begin
        rxSeen_q <= 1'b1;
        indicatorLatched_q <= 1'b0;
      end
    end
  end

  assign indicatorMode = indicatorLatched_q;

  // One terminal: indicator data or serial data, never both.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      txOut <= 1'b1;
    end else if (indicatorLatched_q) begin
      txOut <= indicatorTxData;
    end else begin
      txOut <= serialTxData;
    end
  end

  // Flash timer for the selected decimal point.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      flashCount_q <= 32'h0;
      flash_q <= 1'b0;
    end else if (flashCount_q >= 32'(FLASH_CYCLES - 1)) begin
      flashCount_q <= 32'h0;
      flash_q <= ~flash_q;
    end else begin
      flashCount_q <= flashCount_q + 32'h1;
    end
  end

  // Decimal point one-hot, blanked on alternate flash phases.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      decimalPointSel <= 8'h00;
    end else begin
      decimalPointSel <= flash_q ? (8'h01 << decimal_shift_setting) : 8'h00;
    end
  end

  // The same shift scales both switch values, so they cannot diverge.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      scaledPosition <= '0;
      scaledFeedSpeed <= '0;
    end else begin
      scaledPosition <= (SWITCH_WIDTH+24)'(switchPosition
        * pow10(decimal_shift_setting));
      scaledFeedSpeed <= (SWITCH_WIDTH+24)'(switchFeedSpeed
        * pow10(decimal_shift_setting));
    end
  end

  // Hold bit: reset by power class; large units refuse a one.
  always_ff @(posedge core_clk or negedge rst_b) begin
    // Small units come up holding, large units come up releasing.
    if (!rst_b) begin
      holdBit_q <= ~LARGE_UNIT;
    end else if (LARGE_UNIT) begin
      holdBit_q <= 1'b0;
    end else if (stopWordWrite) begin
      holdBit_q <= stop_switch_word[`HOLD_BIT];
    end
  end

  assign holdBit = holdBit_q;
  assign servoOffReq = ~servoOnIn | serial_servo_off_cmd | powerLoss;
  assign coastSel = stop_switch_word[`STOP_METHOD_BIT];

  // Stop sequencer; coasting skips the brake states when leaving STOP_RUN, but reset starts in STOP_BRAKING.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_q <= STOP_BRAKING;
    end else begin
      case (stop_q)
        STOP_RUN: begin
          if (servoOffReq) begin
            stop_q <= coastSel ? STOP_RELEASED : STOP_BRAKING;
          end
        end
        STOP_BRAKING: begin
          if (!servoOffReq) begin
            stop_q <= STOP_RUN;
          end else if (motorStopped) begin
            stop_q <= holdBit_q ? STOP_HOLD : STOP_RELEASED;
          end
        end
        STOP_HOLD, STOP_RELEASED: begin
          if (!servoOffReq) begin
            stop_q <= STOP_RUN;
          end
        end
        default: begin
          stop_q <= STOP_BRAKING;
        end
      endcase
    end
  end

  // Outputs of the stop path, registered from the state.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      servoOff <= 1'b1;
      dynamic_brake <= 1'b1;
      motorPowerOn <= 1'b0;
      brake_interlock_out <= 1'b1;
    end else begin
      servoOff <= (stop_q != STOP_RUN);
      dynamic_brake <= (stop_q == STOP_BRAKING) || (stop_q == STOP_HOLD);
      motorPowerOn <= (stop_q == STOP_RUN);
      // High applies the holding brake; the relay is outside.
      brake_interlock_out <= (stop_q != STOP_RUN);
    end
  end
endmodule

// ---- design/servo_option_map.svh ----
// Constants for the servo option control block.
`ifndef SERVO_OPTION_MAP_SVH
`define SERVO_OPTION_MAP_SVH
`define EXT_GEN_ENABLE_BIT 14
`define INDICATOR_ENABLE_BIT 9
`define POST_POS_FEEDBACK_BIT 7
`define STOP_METHOD_BIT 6
`define HOLD_BIT 7
`define OPTION_WORD_RESET 16'h0000
`define FEEDBACK_WORD_RESET 16'h0000
`define DEBOUNCE_TIME_US 1000
`define CLOCK_MHZ 20
`define DEBOUNCE_CYCLES (`DEBOUNCE_TIME_US * `CLOCK_MHZ)
`define DECIMAL_SHIFT_MAX 3'h7
`define FLASH_TIME_MS 250
`define FLASH_CYCLES (`FLASH_TIME_MS * 1000 * `CLOCK_MHZ)
`endif

// ---- design/servo_option_pkg.sv ----
// Types shared by the servo option control block.
package servo_option_pkg;
  typedef enum logic [1:0] {
    STOP_RUN,
    STOP_BRAKING,
    STOP_HOLD,
    STOP_RELEASED
  } stop_state_t;
  typedef enum logic {
    SRC_ENCODER,
    SRC_LINE
  } fb_source_t;
endpackage

// ---- design/servo_option_if.sv ----
// Carrier between the contact debouncer and the option control top.
`timescale 1ns/100ps
interface servo_option_if;
  logic selectRaw;
  logic selectOn;
  modport filt (input selectRaw, output selectOn);
  modport top (output selectRaw, input selectOn);
endinterface

// ---- design/contact_debounce.sv ----
// Synchroniser and debouncer for the active-low feedback select contact.
`timescale 1ns/100ps
`include "servo_option_map.svh"
module contact_debounce #(
  parameter int STABLE_CYCLES = `DEBOUNCE_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  servo_option_if.filt sel
);
  logic meta_q;
  logic sync_q;
  logic [31:0] count_q;
  logic level_q;

  // Two flip-flops; only sync_q is looked at by the filter.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= sel.selectRaw;
      sync_q <= meta_q;
    end
  end

  // The level changes only after it has held still for the whole time.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= 32'h0;
      level_q <= 1'b1;
    end else if (sync_q == level_q) begin
      count_q <= 32'h0;
    end else if (count_q >= 32'(STABLE_CYCLES - 1)) begin
      count_q <= 32'h0;
      level_q <= sync_q;
    end else begin
      count_q <= count_q + 32'h1;
    end
  end

  // Contact ON is the low level.
  assign sel.selectOn = ~level_q;
endmodule

// ---- tb/servo_option_ctrl_monitor.sv ----
// Port checker for the servo option control block.
`timescale 1ns/100ps
module servo_option_ctrl_monitor (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [15:0] option_switch_word,
  input wire logic [15:0] stop_switch_word,
  input wire logic [2:0] decimal_shift_setting,
  input wire logic line_feedback_select_b,
  input wire logic servoOnIn,
  input wire logic motorStopped,
  input wire logic serialRxActive,
  input wire logic lineFeedbackActive,
  input wire logic indicatorMode,
  input wire logic [7:0] decimalPointSel,
  input wire logic servoOff,
  input wire logic dynamic_brake,
  input wire logic brake_interlock_out,
  input wire logic holdBit
);
  // All checks share the control clock and the power-up reset.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  stop_entry_a: assert property ($fell(servoOnIn) |-> ##2 servoOff)
    else $error("servo off late");
  brake_stop_a: assert property ($rose(servoOff) |->
    dynamic_brake == !stop_switch_word[6]) else $error("stop method wrong");
  interlock_set_a: assert property ($rose(servoOff) |->
    brake_interlock_out) else $error("brake not applied");
  ext_off_a: assert property (!option_switch_word[14] [*2] |->
    !lineFeedbackActive) else $error("line feedback while disabled");
  // A high contact held past the filter must leave the encoder in charge.
  contact_off_a: assert property (line_feedback_select_b [*8] |=>
    !lineFeedbackActive) else $error("line feedback with contact off");
  rx_exit_a: assert property (indicatorMode && serialRxActive |->
    ##[1:2] !indicatorMode) else $error("indicator kept after receive");
  no_return_a: assert property ($fell(indicatorMode) &&
    option_switch_word[9] |-> !indicatorMode [*4])
    else $error("indicator came back");
  brake_release_a: assert property ($rose(motorStopped) && servoOff &&
    !holdBit && !stop_switch_word[6] |-> ##[2:3] !dynamic_brake)
    else $error("brake not released");
  point_sel_a: assert property ($stable(decimal_shift_setting) &&
    decimalPointSel != 8'h00 |-> decimalPointSel ==
    8'h01 << decimal_shift_setting) else $error("wrong decimal point");
endmodule
bind servo_option_ctrl servo_option_ctrl_monitor monitor_inst (.core_clk,
  .rst_b, .option_switch_word, .stop_switch_word, .decimal_shift_setting,
  .line_feedback_select_b, .servoOnIn, .motorStopped, .serialRxActive,
  .lineFeedbackActive, .indicatorMode, .decimalPointSel, .servoOff,
  .dynamic_brake, .brake_interlock_out, .holdBit);

// ---- tb/field_partner.sv ----
// Field side model: line pulse generator and brake relay.
`timescale 1ns/100ps
module field_partner (
  input wire logic core_clk,
  input wire logic stepReq,
  input wire logic brake_interlock_out,
  output logic ext_phase_a_pos,
  output logic ext_phase_a_neg,
  output logic ext_phase_b_pos,
  output logic ext_phase_b_neg,
  output logic ext_phase_c_pos,
  output logic ext_phase_c_neg,
  output logic relayEngaged
);
  logic [1:0] phase_q = 2'h0;
  // Gray coding so each request moves exactly one edge.
  always @(posedge core_clk) if (stepReq) phase_q <= phase_q + 2'h1;
  assign ext_phase_a_pos = phase_q[1];
  assign ext_phase_b_pos = phase_q[1] ^ phase_q[0];
  assign ext_phase_c_pos = phase_q == 2'h0;
  assign ext_phase_a_neg = !ext_phase_a_pos;
  assign ext_phase_b_neg = !ext_phase_b_pos;
  assign ext_phase_c_neg = !ext_phase_c_pos;
  assign relayEngaged = !brake_interlock_out;
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the servo option control block.
`timescale 1ns/100ps
module tb_top;
  logic core_clk = 1'h0, rst_b = 1'h0;
  logic [15:0] option_switch_word = 16'h0000;
  logic [15:0] feedback_switch_word = 16'h0080;
  logic [15:0] stop_switch_word = 16'h0000;
  logic [2:0] decimal_shift_setting = 3'h0;
  logic [19:0] switchPosition = 20'h0007b, switchFeedSpeed = 20'h001c8;
  logic stopWordWrite = 1'h0, encoderStep = 1'h0, encoderDir = 1'h0;
  logic encoderIndex = 1'h0, line_feedback_select_b = 1'h1, stepReq = 1'h0;
  logic positioningDone = 1'h0, servoOnIn = 1'h0, powerLoss = 1'h0;
  logic serial_servo_off_cmd = 1'h0, motorStopped = 1'h0;
  logic serialRxActive = 1'h0, serialTxData = 1'h1, indicatorTxData = 1'h0;
  logic ext_phase_a_pos, ext_phase_a_neg, ext_phase_b_pos, ext_phase_b_neg;
  logic ext_phase_c_pos, ext_phase_c_neg, relayEngaged, feedbackStep;
  logic feedbackDir, feedbackIndex, lineFeedbackActive, indicatorMode, txOut;
  logic servoOff, dynamic_brake, motorPowerOn, brake_interlock_out, holdBit;
  logic [7:0] decimalPointSel;
  logic [43:0] scaledPosition, scaledFeedSpeed;
  int err_total = 0, comparisons = 0, steps = 0, cycles = 0;
  always #25 core_clk = ~core_clk;
  // Short filter and flash counts keep the run brief.
  servo_option_ctrl #(.DEBOUNCE_CYCLES(4), .FLASH_CYCLES(8))
    servo_option_ctrl_inst (.core_clk, .rst_b, .option_switch_word,
    .feedback_switch_word, .stop_switch_word, .stopWordWrite,
    .decimal_shift_setting, .ext_phase_a_pos, .ext_phase_a_neg,
    .ext_phase_b_pos, .ext_phase_b_neg, .ext_phase_c_pos, .ext_phase_c_neg,
    .encoderStep, .encoderDir, .encoderIndex, .line_feedback_select_b,
    .positioningDone, .servoOnIn, .serial_servo_off_cmd, .powerLoss,
    .motorStopped, .serialRxActive, .serialTxData, .indicatorTxData,
    .switchPosition, .switchFeedSpeed, .feedbackStep, .feedbackDir,
    .feedbackIndex, .lineFeedbackActive, .indicatorMode, .txOut,
    .decimalPointSel, .scaledPosition, .scaledFeedSpeed, .servoOff,
    .dynamic_brake, .motorPowerOn, .brake_interlock_out, .holdBit);
  field_partner field_partner_inst (.core_clk, .stepReq, .brake_interlock_out,
    .ext_phase_a_pos, .ext_phase_a_neg, .ext_phase_b_pos, .ext_phase_b_neg,
    .ext_phase_c_pos, .ext_phase_c_neg, .relayEngaged);
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Count feedback steps; a hung run is cut short well past its length.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (feedbackStep === 1'h1) steps <= steps + 1;
    if (cycles == 5000) begin
      err_total = err_total + 1;
      report_and_stop;
    end
  end
  task automatic chk(input logic [43:0] got, input logic [43:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Waiting past the edge lets its register updates settle first.
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic t_reset;
    w(1);
    chk(servoOff, 1'h1);
    chk(brake_interlock_out, 1'h1);
    chk(holdBit, 1'h1);
    chk(indicatorMode, 1'h0);
  endtask
  task automatic t_feedback;
    @(posedge core_clk);
    option_switch_word <= 16'h4000;
    line_feedback_select_b <= 1'h0;
    w(12);
    chk(lineFeedbackActive, 1'h1);
    steps = 0;
    repeat (5) begin
      @(posedge core_clk);
      stepReq <= 1'h1;
      @(posedge core_clk);
      stepReq <= 1'h0;
      w(3);
    end
    w(6);
    chk(steps, 44'h5);
    @(posedge core_clk);
    positioningDone <= 1'h1;
    w(3);
    chk(lineFeedbackActive, 1'h1);
    @(posedge core_clk);
    feedback_switch_word <= 16'h0000;
    w(3);
    chk(lineFeedbackActive, 1'h0);
    @(posedge core_clk);
    positioningDone <= 1'h0;
    feedback_switch_word <= 16'h0080;
    w(3);
    chk(lineFeedbackActive, 1'h1);
    @(posedge core_clk);
    line_feedback_select_b <= 1'h1;
    w(12);
    chk(lineFeedbackActive, 1'h0);
    @(posedge core_clk);
    line_feedback_select_b <= 1'h0;
    option_switch_word <= 16'h0000;
    w(12);
    chk(lineFeedbackActive, 1'h0);
    @(posedge core_clk);
    encoderStep <= 1'h1;
    encoderDir <= 1'h1;
    encoderIndex <= 1'h1;
    w(1);
    chk(feedbackStep, 1'h1);
    chk(feedbackDir, 1'h1);
    chk(feedbackIndex, 1'h1);
    @(posedge core_clk);
    encoderStep <= 1'h0;
    encoderDir <= 1'h0;
    encoderIndex <= 1'h0;
  endtask
  task automatic t_indicator;
    @(posedge core_clk);
    option_switch_word <= 16'h0200;
    w(3);
    chk(indicatorMode, 1'h1);
    chk(txOut, 1'h0);
    @(posedge core_clk);
    serialRxActive <= 1'h1;
    @(posedge core_clk);
    serialRxActive <= 1'h0;
    w(12);
    chk(indicatorMode, 1'h0);
    chk(txOut, 1'h1);
    // A second power-up with the enable still set brings the mode back.
    @(posedge core_clk);
    rst_b <= 1'h0;
    w(1);
    @(posedge core_clk);
    rst_b <= 1'h1;
    w(3);
    chk(indicatorMode, 1'h1);
    @(posedge core_clk);
    option_switch_word <= 16'h0000;
    w(3);
    chk(indicatorMode, 1'h0);
  endtask
  task automatic t_scale;
    logic [7:0] seen;
    for (int s = 0; s < 8; s++) begin
      @(posedge core_clk);
      decimal_shift_setting <= 3'(s);
      seen = 8'h00;
      repeat (20) begin
        w(1);
        seen = seen | decimalPointSel;
      end
      chk(seen, 8'h01 << s);
      chk(scaledPosition, 44'(longint'(123) * 10 ** s));
      chk(scaledFeedSpeed, 44'(longint'(456) * 10 ** s));
    end
  endtask
  task automatic t_stop(input int cause, input logic coast, input logic hold);
    @(posedge core_clk);
    {servoOnIn, serial_servo_off_cmd, powerLoss} <= 3'h4;
    motorStopped <= 1'h0;
    stop_switch_word <= {8'h00, hold, coast, 6'h00};
    stopWordWrite <= 1'h1;
    @(posedge core_clk);
    stopWordWrite <= 1'h0;
    w(4);
    chk(holdBit, hold);
    chk(relayEngaged, 1'h1);
    @(posedge core_clk);
    if (cause == 0) servoOnIn <= 1'h0;
    else if (cause == 1) serial_servo_off_cmd <= 1'h1;
    else powerLoss <= 1'h1;
    w(4);
    chk(servoOff, 1'h1);
    chk(dynamic_brake, !coast);
    chk(motorPowerOn, 1'h0);
    chk(brake_interlock_out, 1'h1);
    @(posedge core_clk);
    motorStopped <= 1'h1;
    w(4);
    chk(dynamic_brake, hold && !coast);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'h1;
    t_reset;
    t_feedback;
    t_indicator;
    t_scale;
    t_stop(0, 1'h0, 1'h1);
    t_stop(1, 1'h0, 1'h0);
    t_stop(2, 1'h1, 1'h1);
    t_stop(0, 1'h0, 1'h0);
    report_and_stop;
  end
endmodule
